// ===== src/gpp_top.sv
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_top
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [15:0]         padIn,
  input  wire logic [15:0]         periphOut,
  input  wire logic [15:0]         periphOe,
  output      gpp_pkg::gpp_pad_t   pad,
  output      logic [31:0]         padPull,
  output      logic [15:0]         padPullStrong,
  output      logic                irq,
  output      logic                wake,
  input  wire logic                powerButtonInputN,
  output      logic                sleepReq,
  output      logic                wakeReq,
  output      logic                offReq,
  output      logic                resetIndOut,
  output      logic                resetIndOe
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] dir, outVal, filtEn, riseSt, fallSt, intEn, wakeEn, stbyVal;
  logic [15:0] modeGp, pullStrong;
  logic [15:0] filtState;
  logic [31:0] pullSel;
  logic [3:0]  pwmSel;
  logic [5:0]  ctrl;
  gpp_pkg::gpp_pstate_t pstate;
  logic [31:0] pwmBase [`GPP_NPWM];
  logic [7:0]  pwmDuty [`GPP_NPWM];
  logic        standby, standbyQ;

  // write strobe fill of a 32 bit register
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  // write strobe fill of a 16 bit register
  function automatic logic [15:0] wmlo(input logic [15:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] be);
    logic [31:0] r;
    r = wmerge({16'h0000, old}, d, be);
    return r[15:0];
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write path: address and data taken in either order
  // ----------------------------------------------------------------
  logic        awHave, wHave;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  wire         wrFire = awHave && wHave && !s_axi_bvalid;
  wire  [31:0] wm     = wmerge(`GPP_ZERO32, wData, wStrb);
  wire         selPb  = awAddr >= `GPP_A_PBASE && awAddr < `GPP_A_PDUTY;
  wire         selPd  = awAddr >= `GPP_A_PDUTY && awAddr < `GPP_A_PDUTY + 8'h10;
  wire  [1:0]  wIdx   = awAddr[3:2];
  wire         wOk    = awAddr[1:0] == 2'h0 && awAddr <= `GPP_A_LAST;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPP_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wOk ? `GPP_RESP_OK : `GPP_RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rdMux =
    ra == `GPP_A_DIR    ? {16'h0000, dir} :
    ra == `GPP_A_OUT    ? {16'h0000, outVal} :
    ra == `GPP_A_IN     ? {16'h0000, filtState} :
    ra == `GPP_A_FILT   ? {16'h0000, filtEn} :
    ra == `GPP_A_RISE   ? {16'h0000, riseSt} :
    ra == `GPP_A_FALL   ? {16'h0000, fallSt} :
    ra == `GPP_A_IEN    ? {wakeEn, intEn} :
    ra == `GPP_A_STBY   ? {16'h0000, stbyVal} :
    ra == `GPP_A_PULL   ? pullSel :
    ra == `GPP_A_PULLI  ? {16'h0000, pullStrong} :
    ra == `GPP_A_MODE   ? {16'h0000, modeGp} :
    ra == `GPP_A_PWMSEL ? {28'h0000000, pwmSel} :
    ra == `GPP_A_PSTATE ? {28'h0000000, pstate} :
    ra == `GPP_A_CTRL   ? {26'h0000000, ctrl} :
    (ra >= `GPP_A_PBASE && ra < `GPP_A_PDUTY) ? pwmBase[ra[3:2]] :
    (ra >= `GPP_A_PDUTY && ra < `GPP_A_PDUTY + 8'h10) ? {24'h000000, pwmDuty[ra[3:2]]} :
    `GPP_ZERO32;
  wire rOk = ra[1:0] == 2'h0 && ra <= `GPP_A_LAST && ra != `GPP_A_SET
             && ra != `GPP_A_CLR;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `GPP_ZERO32;
      s_axi_rresp <= `GPP_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rOk ? rdMux : `GPP_ZERO32;
      s_axi_rresp <= rOk ? `GPP_RESP_OK : `GPP_RESP_ERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // ready flags come from flops: low in reset, low while a beat is held
  wire awTake      = s_axi_awvalid && s_axi_awready;
  wire wTake       = s_axi_wvalid && s_axi_wready;
  wire arTake      = s_axi_arvalid && s_axi_arready;
  wire next_awHave = !wrFire && (awTake || awHave);
  wire next_wHave  = !wrFire && (wTake || wHave);
  wire next_rvalid = arTake || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !next_awHave;
      s_axi_wready <= !next_wHave;
      s_axi_arready <= !next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // filter clock enable per power state
  // ----------------------------------------------------------------
  // fractional enable: add target rate, tick on wrap past clk rate
  logic [31:0] fAcc;
  logic        fTick;
  wire  [31:0] fRate = pstate == gpp_pkg::GPP_ST_ACTIVE ? 32'(`GPP_F_ACTIVE) :
                       pstate == gpp_pkg::GPP_ST_DEEP   ? 32'(`GPP_F_DEEP) :
                       32'(`GPP_F_IDLE);
  wire  [31:0] fSum  = fAcc + fRate;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fAcc <= `GPP_ZERO32;
      fTick <= 1'b0;
    end
    else
    begin
      fTick <= fSum >= 32'(`GPP_CLK_HZ);
      fAcc <= fSum >= 32'(`GPP_CLK_HZ) ? fSum - 32'(`GPP_CLK_HZ) : fSum;
    end
  end

  // ----------------------------------------------------------------
  // glitch filter and edge capture
  // ----------------------------------------------------------------
  logic [15:0] rawQ, filtPrev;
  logic [`GPP_FILT_LEN_W-1:0] fCnt [`GPP_NPIN];
  wire  [15:0] isIn   = ~dir & modeGp;
  wire  [15:0] rise   = filtState & ~filtPrev & isIn;
  wire  [15:0] fall   = ~filtState & filtPrev & isIn;
  wire  [15:0] rClr   = (wrFire && awAddr == `GPP_A_RISE) ? wm[15:0] : 16'h0000;
  wire  [15:0] fClr   = (wrFire && awAddr == `GPP_A_FALL) ? wm[15:0] : 16'h0000;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rawQ <= 16'h0000;
      filtState <= 16'h0000;
      filtPrev <= 16'h0000;
      riseSt <= 16'h0000;
      fallSt <= 16'h0000;
      for (int i = 0; i < `GPP_NPIN; i++)
        fCnt[i] <= '0;
    end
    else
    begin
      filtPrev <= filtState;
      riseSt <= (riseSt & ~rClr) | rise;
      fallSt <= (fallSt & ~fClr) | fall;
      if (fTick)
      begin
        rawQ <= padIn;
        for (int i = 0; i < `GPP_NPIN; i++)
        begin
          if (!filtEn[i])
            filtState[i] <= rawQ[i];
          else if (rawQ[i] == filtState[i])
            fCnt[i] <= '0;
          else if (fCnt[i] == `GPP_FILT_LEN_W'(`GPP_FILT_LEN - 2))
          begin
            filtState[i] <= rawQ[i];
            fCnt[i] <= '0;
          end
          else
            fCnt[i] <= fCnt[i] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dir <= 16'h0000;
      outVal <= 16'h0000;
      filtEn <= `GPP_RST_FILT;
      intEn <= 16'h0000;
      wakeEn <= 16'h0000;
      stbyVal <= 16'h0000;
      pullSel <= `GPP_ZERO32;
      pullStrong <= 16'h0000;
      modeGp <= `GPP_RST_MODE;
      pwmSel <= 4'h0;
      pstate <= gpp_pkg::GPP_ST_ACTIVE;
      ctrl <= 6'h00;
      for (int i = 0; i < `GPP_NPWM; i++)
      begin
        pwmBase[i] <= `GPP_ZERO32;
        pwmDuty[i] <= 8'h00;
      end
    end
    else if (wrFire && wOk)
    begin
      if (awAddr == `GPP_A_DIR)
        dir <= wmlo(dir, wData, wStrb);
      else if (awAddr == `GPP_A_OUT)
        outVal <= wmlo(outVal, wData, wStrb);
      else if (awAddr == `GPP_A_SET)
        outVal <= outVal | wm[15:0];
      else if (awAddr == `GPP_A_CLR)
        outVal <= outVal & ~wm[15:0];
      else if (awAddr == `GPP_A_FILT)
        filtEn <= wmlo(filtEn, wData, wStrb);
      else if (awAddr == `GPP_A_IEN)
        {wakeEn, intEn} <= wmerge({wakeEn, intEn}, wData, wStrb);
      else if (awAddr == `GPP_A_STBY)
        stbyVal <= wmlo(stbyVal, wData, wStrb);
      else if (awAddr == `GPP_A_PULL)
        pullSel <= wmerge(pullSel, wData, wStrb);
      else if (awAddr == `GPP_A_PULLI)
        pullStrong <= wmlo(pullStrong, wData, wStrb);
      else if (awAddr == `GPP_A_MODE)
        modeGp <= wmlo(modeGp, wData, wStrb);
      else if (awAddr == `GPP_A_PWMSEL)
        pwmSel <= wm[3:0];
      else if (awAddr == `GPP_A_PSTATE && $onehot(wm[3:0]))
        pstate <= gpp_pkg::gpp_pstate_t'(wm[3:0]);
      else if (awAddr == `GPP_A_CTRL)
        ctrl <= wm[5:0];
      else if (selPb)
        pwmBase[wIdx] <= wmerge(pwmBase[wIdx], wData, wStrb);
      else if (selPd)
        pwmDuty[wIdx] <= wm[7:0];
    end
  end

  // ----------------------------------------------------------------
  // pwm generators: 19.2 MHz enable, phase accumulator
  // ----------------------------------------------------------------
  logic [31:0] pAcc;
  logic        pTick;
  wire  [31:0] pSum = pAcc + 32'(`GPP_F_PWM);
  logic [`GPP_ACC_W-1:0] phase [`GPP_NPWM];
  logic [3:0]  pwmOut;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pAcc <= `GPP_ZERO32;
      pTick <= 1'b0;
      pwmOut <= 4'h0;
      for (int i = 0; i < `GPP_NPWM; i++)
        phase[i] <= '0;
    end
    else
    begin
      pTick <= pSum >= 32'(`GPP_CLK_HZ);
      pAcc <= pSum >= 32'(`GPP_CLK_HZ) ? pSum - 32'(`GPP_CLK_HZ) : pSum;
      for (int i = 0; i < `GPP_NPWM; i++)
      begin
        if (pTick)
          phase[i] <= phase[i] + pwmBase[i][`GPP_INC_HI:`GPP_INC_LO];
        pwmOut[i] <= phase[i][`GPP_ACC_W-1 -: 8] < pwmDuty[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // pads, standby, power button, reset indicator
  // ----------------------------------------------------------------
  wire [15:0] gpOut = standby ? stbyVal : outVal;
  wire [15:0] mixOut = (modeGp & gpOut) | (~modeGp & periphOut);
  wire [15:0] mixOe  = (modeGp & dir) | (~modeGp & periphOe);
  logic       pbQ;
  assign standby = pstate != gpp_pkg::GPP_ST_ACTIVE;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pad <= '0;
      padPull <= `GPP_ZERO32;
      padPullStrong <= 16'h0000;
      irq <= 1'b0;
      wake <= 1'b0;
      pbQ <= 1'b1;
      sleepReq <= 1'b0;
      wakeReq <= 1'b0;
      offReq <= 1'b0;
      standbyQ <= 1'b0;
      resetIndOut <= 1'b0;
      resetIndOe <= 1'b1;
    end
    else
    begin
      standbyQ <= standby;
      pad.padOut <= {mixOut[15:4], pwmSel & pwmOut | ~pwmSel & mixOut[3:0]};
      pad.padOe <= {mixOe[15:4], pwmSel | mixOe[3:0]};
      padPull <= pullSel;
      padPullStrong <= pullStrong;
      irq <= |((riseSt | fallSt) & intEn);
      wake <= |((riseSt | fallSt) & wakeEn);
      pbQ <= powerButtonInputN;
      sleepReq <= pbQ && !powerButtonInputN && ctrl[0];
      wakeReq <= pbQ && !powerButtonInputN && ctrl[1];
      offReq <= pbQ && !powerButtonInputN && ctrl[2];
      resetIndOe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_dirReset;
    @(posedge clk) $fell(reset) |-> pad.padOe[15:4] == 12'h000;
  endproperty
  a_dirReset: assert property (p_dirReset) else $error("pins not inputs after reset");
  property p_rstInd;
    @(posedge clk) $fell(reset) |-> resetIndOe && !resetIndOut;
  endproperty
  a_rstInd: assert property (p_rstInd) else $error("reset indicator not low");
  property p_irq;
    @(posedge clk) disable iff (reset) |(riseSt & intEn) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_sticky;
    @(posedge clk) disable iff (reset) |rise |=> |riseSt;
  endproperty
  a_sticky: assert property (p_sticky) else $error("edge lost");
  property p_set;
    @(posedge clk) disable iff (reset)
      wrFire && awAddr == `GPP_A_SET |=> (outVal & $past(wm[15:0])) == $past(wm[15:0]);
  endproperty
  a_set: assert property (p_set) else $error("set failed");
  property p_clr;
    @(posedge clk) disable iff (reset)
      wrFire && awAddr == `GPP_A_CLR |=> (outVal & $past(wm[15:0])) == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_pwm;
    @(posedge clk) disable iff (reset) pwmDuty[0] == 8'h00 |=> !pwmOut[0];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm high at zero duty");
  property p_pb;
    @(posedge clk) disable iff (reset) $fell(powerButtonInputN) && ctrl[0] |=> sleepReq;
  endproperty
  a_pb: assert property (p_pb) else $error("button ignored");
endmodule

// ===== pkg/gpp_defs.svh
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
// ----------------------------------------------------------------
// sizes and register map
// ----------------------------------------------------------------
`define GPP_NPIN        16
`define GPP_NPWM        4
`define GPP_A_DIR       8'h00
`define GPP_A_OUT       8'h04
`define GPP_A_SET       8'h08
`define GPP_A_CLR       8'h0C
`define GPP_A_IN        8'h10
`define GPP_A_FILT      8'h14
`define GPP_A_RISE      8'h18
`define GPP_A_FALL      8'h1C
`define GPP_A_IEN       8'h20
`define GPP_A_STBY      8'h24
`define GPP_A_PULL      8'h28
`define GPP_A_PULLI     8'h2C
`define GPP_A_MODE      8'h30
`define GPP_A_PWMSEL    8'h34
`define GPP_A_PSTATE    8'h38
`define GPP_A_CTRL      8'h3C
`define GPP_A_PBASE     8'h40
`define GPP_A_PDUTY     8'h50
`define GPP_A_LAST      8'h5C
// ----------------------------------------------------------------
// fields, resets and timing
// ----------------------------------------------------------------
`define GPP_INC_HI      29
`define GPP_INC_LO      8
`define GPP_ACC_W       22
`define GPP_FILT_LEN    5
`define GPP_FILT_LEN_W  3
`define GPP_CLK_HZ      100000000
`define GPP_F_ACTIVE    50000000
`define GPP_F_IDLE      19200000
`define GPP_F_DEEP      32768
`define GPP_F_PWM       19200000
`define GPP_ZERO32      32'h0000_0000
`define GPP_RST_FILT    16'hFFFF
`define GPP_RST_MODE    16'hFFFF
`define GPP_RESP_OK     2'h0
`define GPP_RESP_ERR    2'h2
`endif

// ===== pkg/gpp_pkg.sv
package gpp_pkg;
  typedef enum logic [3:0] {
    GPP_ST_ACTIVE = 4'h1,
    GPP_ST_IDLE_A = 4'h2,
    GPP_ST_IDLE_B = 4'h4,
    GPP_ST_DEEP   = 4'h8
  } gpp_pstate_t;
  typedef struct packed {
    logic [15:0] padOut;
    logic [15:0] padOe;
  } gpp_pad_t;
endpackage

// ===== test/gpp_sensor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sensors on the general purpose pins
// ----------------------------------------------------------------
module gpp_sensor
(
  input  wire gpp_pkg::gpp_pad_t pad,
  input  wire logic              resetIndOut,
  input  wire logic              resetIndOe,
  input  wire logic [15:0]       drv,
  output      logic              resetLine,
  output      logic [15:0]       padIn
);
  logic [15:0] follow;
  // open-drain indicator with board pull-up
  assign resetLine = resetIndOe ? resetIndOut : 1'b1;
  // pin outputs are ignored until the indicator is released
  assign follow = resetLine ? pad.padOe : 16'h0000;
  assign padIn = (follow & pad.padOut) | (~follow & drv);
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "gpp_defs.svh"
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk, reset, powerButtonInputN, resetLine;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, padPull, rv;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, irq, wake;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
  logic [15:0]       padIn, periphOut, periphOe, padPullStrong, drv;
  logic              sleepReq, wakeReq, offReq, resetIndOut, resetIndOe;
  gpp_pkg::gpp_pad_t pad;
  int                n_fail, compares;

  gpp_top uut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .padIn, .periphOut,
    .periphOe, .pad, .padPull, .padPullStrong, .irq, .wake, .powerButtonInputN,
    .sleepReq, .wakeReq, .offReq, .resetIndOut, .resetIndOe);
  gpp_sensor sensor (.pad, .resetIndOut, .resetIndOe, .drv, .resetLine, .padIn);

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkr(input int got, input int lo, input int hi, input string m);
    compares++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %0d", $time, m, got);
    end
  endtask
  task automatic lim(input int n, input int mx);
    if (n >= mx)
    begin
      n_fail++;
      $display("MISMATCH %0t bus timeout", $time);
      results();
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, da, dw, db;
    int n;
    da = 0; dw = 0; db = 0; n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(da && dw) && n < 50)
    begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
      n++;
    end
    s_axi_bready <= 1'b1;
    while (!db && n < 100)
    begin
      @(negedge clk);
      db = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk);
      n++;
    end
    s_axi_bready <= 1'b0;
    lim(n, 100);
    chkv(32'(rr), 32'(`GPP_RESP_OK), "write resp");
  endtask
  // read: rready held from the request until rvalid is seen
  task automatic rd(input logic [7:0] a);
    bit ta, dr;
    int n;
    ta = 0; dr = 0; n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dr && n < 100)
    begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      dr = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    lim(n, 100);
  endtask
  task automatic hold(input logic [15:0] v, input int n);
    drv <= v;
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_out();
    wr(`GPP_A_DIR, 32'h0000_FFFF);
    wr(`GPP_A_OUT, 32'h0000_00F0);
    wr(`GPP_A_SET, 32'h0000_0005);
    wr(`GPP_A_CLR, 32'h0000_0010);
    @(negedge clk);
    chkv(32'(pad.padOe), 32'h0000_FFFF, "all outputs");
    chkv(32'(pad.padOut), 32'h0000_00E5, "set clear pins");
    rd(`GPP_A_SET);
    chkv(32'(rr), 32'(`GPP_RESP_ERR), "set reg read");
    rd(8'hFC);
    chkv({rr, rv[29:0]}, 32'h8000_0000, "unmapped read");
    wr(`GPP_A_PULL, 32'h0000_0003);
    wr(`GPP_A_PULLI, 32'h0000_0001);
    @(negedge clk);
    chkv(padPull, 32'h0000_0003, "pull code");
    chkv(32'(padPullStrong), 32'h0000_0001, "strong pull");
  endtask
  task automatic t_mode();
    wr(`GPP_A_DIR, 32'h0000_0002);
    wr(`GPP_A_OUT, 32'h0000_0000);
    wr(`GPP_A_MODE, 32'h0000_FFFE);
    periphOut <= 16'h0001;
    periphOe <= 16'h0001;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chkv({pad.padOe[0], pad.padOut[0]}, 32'h3, "peripheral pin");
    wr(`GPP_A_MODE, 32'h0000_FFFF);
    @(negedge clk);
    chkv(32'(pad.padOe[0]), 32'h0, "back to input");
  endtask
  task automatic t_stby();
    wr(`GPP_A_STBY, 32'h0000_0002);
    wr(`GPP_A_PSTATE, 32'h0000_0002);
    hold(16'h0010, 12);
    hold(16'h0000, 40);
    @(negedge clk);
    chkv(32'(pad.padOut[1]), 32'h1, "idle level");
    rd(`GPP_A_RISE);
    chkv(rv, 32'h0, "idle filter rate");
    wr(`GPP_A_PSTATE, 32'h0000_0004);
    hold(16'h0010, 40);
    rd(`GPP_A_RISE);
    chkv(rv, 32'h0000_0010, "idle edge");
    hold(16'h0000, 40);
    wr(`GPP_A_RISE, 32'h0000_FFFF);
    wr(`GPP_A_FALL, 32'h0000_FFFF);
    wr(`GPP_A_PSTATE, 32'h0000_0008);
    hold(16'h0010, 100);
    hold(16'h0000, 5);
    @(negedge clk);
    chkv(32'(pad.padOut[1]), 32'h1, "standby level");
    rd(`GPP_A_RISE);
    chkv(rv, 32'h0, "slow filter");
    wr(`GPP_A_PSTATE, 32'h0000_0001);
    @(negedge clk);
    chkv(32'(pad.padOut[1]), 32'h0, "active level");
  endtask
  task automatic t_edge();
    wr(`GPP_A_IEN, 32'h0010_0010);
    hold(16'h0010, 1);
    hold(16'h0000, 20);
    rd(`GPP_A_RISE);
    chkv(rv, 32'h0, "glitch");
    hold(16'h0010, 30);
    rd(`GPP_A_IN);
    chkv(rv, 32'h0000_0010, "filtered in");
    rd(`GPP_A_RISE);
    chkv(rv, 32'h0000_0010, "rise flag");
    chkv({irq, wake}, 32'h3, "irq and wake");
    hold(16'h0000, 30);
    rd(`GPP_A_FALL);
    chkv(rv, 32'h0000_0010, "fall flag");
    wr(`GPP_A_RISE, 32'h0000_0010);
    wr(`GPP_A_FALL, 32'h0000_0010);
    wr(`GPP_A_IEN, 32'h0000_0000);
    hold(16'h0010, 30);
    rd(`GPP_A_RISE);
    chkv({irq, wake, rv[29:0]}, 32'h0000_0010, "masked edge");
    hold(16'h0000, 30);
  endtask
  task automatic t_pwm();
    int base[4] = '{32'h1000_0000, 32'h1000_0000, 32'h2000_0000, 32'h1000_0000};
    int duty[4] = '{8'h80, 8'h40, 8'h80, 8'h00};
    int hl[4] = '{900, 400, 900, 0};
    int hh[4] = '{1100, 600, 1100, 0};
    int el[4] = '{86, 86, 182, 0};
    int eh[4] = '{106, 106, 202, 0};
    int hi, ed;
    logic last;
    wr(`GPP_A_PWMSEL, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(`GPP_A_PBASE, base[i]);
      wr(`GPP_A_PDUTY, duty[i]);
      repeat (100) @(posedge clk);
      hi = 0; ed = 0; last = 1'b1;
      repeat (2000)
      begin
        @(negedge clk);
        hi += int'(pad.padOut[0] === 1'b1);
        ed += int'(pad.padOut[0] === 1'b1 && last === 1'b0);
        last = pad.padOut[0];
      end
      chkr(hi, hl[i], hh[i], "pwm high time");
      chkr(ed, el[i], eh[i], "pwm periods");
    end
  endtask
  task automatic t_btn();
    logic [2:0] seen;
    for (int i = 0; i < 3; i++)
    begin
      wr(`GPP_A_CTRL, 32'(1 << i));
      powerButtonInputN <= 1'b0;
      seen = 3'h0;
      repeat (8)
      begin
        @(negedge clk);
        seen |= {offReq, wakeReq, sleepReq};
      end
      powerButtonInputN <= 1'b1;
      repeat (4) @(posedge clk);
      chkv(32'(seen), 32'(1 << i), "button action");
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    compares = 0;
    reset = 1'b1;
    powerButtonInputN = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {drv, periphOut, periphOe} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chkv(32'(pad.padOe), 32'h0, "oe in reset");
    chkv(32'(resetLine), 32'h0, "indicator in reset");
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chkv({resetLine, pad.padOe}, 32'h0001_0000, "after reset");
    rd(`GPP_A_DIR);
    chkv(rv, 32'h0, "dir reset");
    rd(`GPP_A_FILT);
    chkv(rv, 32'h0000_FFFF, "filter reset");
    t_out();
    t_mode();
    t_stby();
    t_edge();
    t_pwm();
    t_btn();
    results();
  end
endmodule
